// ---- common/rx_status_pkg.sv ----
// package: offsets, status word layout, limits, carriers and states of the receive status block
`default_nettype none
package rx_status_pkg;

  // register offsets on the host port
  localparam logic [7:0] STATUS_OFFSET = 8'h7C; // per-frame status word, read only
  localparam logic [7:0] CTRL_OFFSET = 8'h60; // receive control, pass-bad setting
  localparam logic [7:0] COUNT_OFFSET = 8'h62; // frames waiting in the status queue

  // status word field positions
  localparam int unsigned BIT_VALID = 15; // frame ready flag
  localparam int unsigned BIT_ICMP = 13; // icmp checksum bad
  localparam int unsigned BIT_IPHDR = 12; // ip header checksum bad
  localparam int unsigned BIT_TCP = 11; // tcp checksum bad
  localparam int unsigned BIT_UDP = 10; // udp checksum bad
  localparam int unsigned BIT_BCAST = 7; // broadcast destination
  localparam int unsigned BIT_GROUP = 6; // multicast destination, broadcast included
  localparam int unsigned BIT_INDIV = 5; // unicast destination
  localparam int unsigned BIT_SYMERR = 4; // symbol error seen on the link
  localparam int unsigned BIT_ETYPE = 3; // type field above the length limit
  localparam int unsigned BIT_LONG = 2; // frame longer than the maximum
  localparam int unsigned BIT_SHORT = 1; // runt frame
  localparam int unsigned BIT_CRC = 0; // crc mismatch
  localparam logic [15:0] RESERVED_MASK = 16'h4300; // bits 14, 9 and 8 always read zero

  // control register layout and reset value
  localparam int unsigned CTRL_PASS_BAD_BIT = 0; // keep bad frames in the queue when set
  localparam logic [15:0] CTRL_RESET = 16'h0000; // bad frames dropped after reset

  // frame size limits in bytes
  localparam logic [11:0] MAX_FRAME_BYTES = 12'h07D0; // 2000
  localparam logic [15:0] TYPE_LEN_LIMIT = 16'h05DC; // 1500
  localparam logic [11:0] COLLISION_WINDOW_BYTES = 12'h0040; // 64
  localparam logic [11:0] DEST_LAST_INDEX = 12'h0005; // destination address bytes 0..5
  localparam logic [11:0] TYPE_HI_INDEX = 12'h000C; // length/type field, high byte
  localparam logic [11:0] TYPE_LO_INDEX = 12'h000D; // length/type field, low byte
  localparam logic [11:0] LEN_SATURATE = 12'hFFF; // byte counter stops here

  // one received byte from the mac
  typedef struct packed {
    logic valid; // byte present this cycle
    logic first; // first byte of the frame
    logic last; // last byte of the frame
    logic [7:0] data; // byte value
  } rx_byte_s;

  // error and checker results, any of them may rise at any byte of the frame
  typedef struct packed {
    logic symbol_err; // line symbol error
    logic collision; // collision during reception
    logic crc_bad; // crc mismatch, with the last byte
    logic icmp_bad; // icmp checksum wrong
    logic ip_bad; // ip header checksum wrong
    logic tcp_bad; // tcp checksum wrong
    logic udp_bad; // udp checksum wrong
  } rx_check_s;

  // host register request
  typedef struct packed {
    logic wr; // write strobe
    logic rd; // read strobe
    logic [7:0] addr; // byte offset
    logic [15:0] wdata; // write data
  } reg_req_s;

  // receive tracking states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, // waiting for a first byte
    ST_RECV = 3'b010, // inside a frame
    ST_DONE = 3'b100 // frame ended, decide and commit
  } rx_state_e;

endpackage : rx_status_pkg
`default_nettype wire

// ---- verilog/status_queue.sv ----
// module: first-in first-out store of completed frame status words
`default_nettype none
module status_queue #(
  parameter int unsigned WIDTH = 16, // bits per status word
  parameter int unsigned SLOT_BITS = 4 // log2 of the number of slots
) (
  input wire logic clk_in, // clock
  input wire logic srst_in, // synchronous reset, active high
  input wire logic push_in, // store a word, ignored when full
  input wire logic [WIDTH-1:0] push_word_in, // word to store
  input wire logic pop_in, // drop the head, ignored when empty
  output logic [WIDTH-1:0] head_out, // oldest word
  output logic [SLOT_BITS:0] count_out, // words held
  output logic full_out, // no room left
  output logic empty_out // nothing held
);

  localparam int unsigned SLOTS = 1 << SLOT_BITS; // number of slots

  logic [WIDTH-1:0] mem_q [SLOTS]; // word storage
  logic [SLOT_BITS-1:0] wr_ptr_q; // next slot to write
  logic [SLOT_BITS-1:0] rd_ptr_q; // head slot
  logic [SLOT_BITS:0] count_q; // fill level
  logic do_push; // accepted push
  logic do_pop; // accepted pop

  // a pop on an empty queue or a push on a full one would corrupt the pointers
  assign do_push = push_in && (count_q != SLOTS[SLOT_BITS:0]);
  assign do_pop = pop_in && (count_q != '0);

  // storage needs no reset, only slots below the fill level are read
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= push_word_in;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_q <= count_q + 1'b1;
      end else if (do_pop && !do_push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  assign head_out = mem_q[rd_ptr_q];
  assign count_out = count_q;
  assign full_out = (count_q == SLOTS[SLOT_BITS:0]);
  assign empty_out = (count_q == '0);

endmodule : status_queue
`default_nettype wire

// ---- verilog/rx_frame_header_status.sv ----
// module: receive frame status capture, per-frame status queue and host register port
`default_nettype none
module rx_frame_header_status #(
  parameter int unsigned SLOT_BITS = 4 // log2 of frames the status queue holds
) (
  input wire logic clk_in, // 20 MHz clock
  input wire logic srst_in, // synchronous reset, active high
  input wire rx_status_pkg::rx_byte_s rx_byte_in, // byte stream from the mac
  input wire rx_status_pkg::rx_check_s rx_check_in, // error and checksum results
  input wire rx_status_pkg::reg_req_s reg_req_in, // host register request
  output logic [15:0] rd_data_out, // read data, one cycle after the read strobe
  output logic frame_pending_out, // at least one status word waits
  output logic frame_dropped_out // one-cycle pulse, a frame was discarded
);
  import rx_status_pkg::*;

  // receive tracking
  rx_state_e state_q; // tracking state
  rx_state_e state_d; // next tracking state
  logic [11:0] len_q; // bytes counted so far, saturating
  logic [11:0] len_d; // next byte count
  logic [11:0] byte_idx; // position of the byte on the stream now
  logic dest_ones_q; // every destination byte so far was all ones
  logic group_q; // group bit of the destination address
  logic [15:0] type_q; // length/type field
  rx_check_s err_q; // sticky errors of the current frame
  rx_check_s err_d; // next sticky errors

  // commit decision
  logic [15:0] word; // status word of the finished frame
  logic is_long; // longer than the maximum
  logic is_short; // runt
  logic is_bad; // any condition that needs pass-bad
  logic keep; // frame goes into the queue
  logic push; // word stored this cycle

  // host side
  logic [15:0] ctrl_q; // control register
  logic pass_bad; // bad frames kept when set
  logic st_read; // read strobe on the status word
  logic pop; // head leaves the queue
  logic [15:0] head; // oldest status word
  logic [SLOT_BITS:0] count; // frames waiting
  logic q_full; // queue has no room
  logic q_empty; // queue holds nothing

  // the byte index is 0 on the first byte whatever the counter still holds
  assign byte_idx = rx_byte_in.first ? '0 : len_q;

  // next state: a frame of a single byte goes straight to the commit cycle
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (rx_byte_in.valid && rx_byte_in.first) begin
          state_d = rx_byte_in.last ? ST_DONE : ST_RECV;
        end
      end
      ST_RECV: begin
        if (rx_byte_in.valid && rx_byte_in.last) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE; // illegal code, recover to idle
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // byte counter keeps running past the maximum, the frame is never cut short
  always_comb begin
    len_d = len_q;
    if (rx_byte_in.valid && rx_byte_in.first) begin
      len_d = 12'h001;
    end else if (rx_byte_in.valid && (state_q == ST_RECV) && (len_q != LEN_SATURATE)) begin
      len_d = len_q + 12'h001;
    end
  end

  // counter register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      len_q <= '0;
    end else begin
      len_q <= len_d;
    end
  end

  // destination address class from bytes 0..5
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dest_ones_q <= 1'b0;
      group_q <= 1'b0;
    end else if (rx_byte_in.valid && byte_idx <= DEST_LAST_INDEX) begin
      if (rx_byte_in.first) begin
        dest_ones_q <= (rx_byte_in.data == 8'hFF);
        group_q <= rx_byte_in.data[0];
      end else begin
        dest_ones_q <= dest_ones_q && (rx_byte_in.data == 8'hFF);
      end
    end
  end

  // length/type field from bytes 12 and 13; frames of 12 bytes or fewer leave it zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      type_q <= '0;
    end else if (rx_byte_in.valid) begin
      if (rx_byte_in.first) begin
        type_q <= '0;
      end else if (byte_idx == TYPE_HI_INDEX) begin
        type_q[15:8] <= rx_byte_in.data;
      end else if (byte_idx == TYPE_LO_INDEX) begin
        type_q[7:0] <= rx_byte_in.data;
      end
    end
  end

  // sticky errors; the first byte restarts them but still takes its own results,
  // so an error on that very cycle is not lost
  always_comb begin
    err_d = err_q;
    if (rx_byte_in.valid && rx_byte_in.first) begin
      err_d = rx_check_in;
    end else if (state_q == ST_RECV) begin
      err_d = err_q | rx_check_in;
    end
  end

  // error register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      err_q <= '0;
    end else begin
      err_q <= err_d;
    end
  end

  // classification of the finished frame
  assign is_long = (len_q > MAX_FRAME_BYTES);
  assign is_short = err_q.collision || (len_q < COLLISION_WINDOW_BYTES);
  assign is_bad = is_long || is_short || err_q.crc_bad;

  // status word; bit 15 is added at read time from the queue level
  always_comb begin
    word = '0;
    word[BIT_ICMP] = err_q.icmp_bad;
    word[BIT_IPHDR] = err_q.ip_bad;
    word[BIT_TCP] = err_q.tcp_bad;
    word[BIT_UDP] = err_q.udp_bad;
    word[BIT_BCAST] = group_q && dest_ones_q;
    word[BIT_GROUP] = group_q;
    word[BIT_INDIV] = !group_q;
    word[BIT_SYMERR] = err_q.symbol_err;
    word[BIT_ETYPE] = (type_q > TYPE_LEN_LIMIT);
    word[BIT_LONG] = is_long;
    word[BIT_SHORT] = is_short;
    word[BIT_CRC] = err_q.crc_bad;
  end

  // bad frames survive only with pass-bad; a full queue loses the frame, as
  // there is no place to report it
  assign keep = !is_bad || pass_bad;
  assign push = (state_q == ST_DONE) && keep && !q_full;

  // drop pulse for the counters outside
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      frame_dropped_out <= 1'b0;
    end else begin
      frame_dropped_out <= (state_q == ST_DONE) && !(keep && !q_full);
    end
  end

  // control register, only the pass-bad bit is stored
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_req_in.wr && reg_req_in.addr == CTRL_OFFSET) begin
      ctrl_q <= reg_req_in.wdata & (16'h0001 << CTRL_PASS_BAD_BIT);
    end
  end
  assign pass_bad = ctrl_q[CTRL_PASS_BAD_BIT];

  // each status read hands out one frame; reads on an empty queue do not move it
  assign st_read = reg_req_in.rd && (reg_req_in.addr == STATUS_OFFSET);
  assign pop = st_read && !q_empty;

  // status queue, one word per frame
  status_queue #(
    .WIDTH(16),
    .SLOT_BITS(SLOT_BITS)
  ) u_queue (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .push_in(push),
    .push_word_in(word),
    .pop_in(pop),
    .head_out(head),
    .count_out(count),
    .full_out(q_full),
    .empty_out(q_empty)
  );

  // read data register; unmapped offsets answer zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rd_data_out <= '0;
    end else if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        STATUS_OFFSET: begin
          if (q_empty) begin
            rd_data_out <= '0;
          end else begin
            rd_data_out <= (head & ~RESERVED_MASK) | (16'h0001 << BIT_VALID);
          end
        end
        CTRL_OFFSET: begin
          rd_data_out <= ctrl_q;
        end
        COUNT_OFFSET: begin
          rd_data_out <= 16'(count);
        end
        default: begin
          rd_data_out <= '0;
        end
      endcase
    end
  end

  // pending level, registered from the next queue level so it matches the queue after each edge
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      frame_pending_out <= 1'b0;
    end else begin
      frame_pending_out <= (count - (pop ? 1'b1 : 1'b0) + (push ? 1'b1 : 1'b0)) != '0;
    end
  end

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  sequence seq_status_read_full;
    st_read && !q_empty;
  endsequence

  sequence seq_status_read_empty;
    st_read && q_empty;
  endsequence

  sequence seq_commit_bad_blocked;
    (state_q == ST_DONE) && is_bad && !pass_bad;
  endsequence

  AST_VALID_WHEN_PENDING: assert property (seq_status_read_full |=> rd_data_out[BIT_VALID])
    else $error("valid bit missing while a frame waits");
  AST_CLEAR_WHEN_EMPTY: assert property (seq_status_read_empty |=> rd_data_out == '0)
    else $error("status word not zero on empty queue");
  AST_RESERVED_ZERO: assert property (st_read |=> (rd_data_out & RESERVED_MASK) == '0)
    else $error("reserved status bit read as one");
  AST_BCAST_IS_GROUP: assert property (push && word[BIT_BCAST] |-> word[BIT_GROUP] && !word[BIT_INDIV])
    else $error("broadcast without multicast flag");
  AST_INDIV_EXCLUSIVE: assert property (push |-> word[BIT_INDIV] != word[BIT_GROUP])
    else $error("unicast and multicast flags agree");
  AST_BAD_DROPPED: assert property (seq_commit_bad_blocked |-> !push ##1 frame_dropped_out)
    else $error("bad frame kept without pass-bad");
  AST_LONG_FLAG: assert property (push |-> word[BIT_LONG] == (len_q > 12'h07D0))
    else $error("oversize flag does not match length");
  AST_TYPE_FLAG: assert property (push |-> word[BIT_ETYPE] == (type_q > 16'h05DC))
    else $error("frame type flag does not match field");
  AST_CRC_SEEN: assert property (state_q == ST_RECV && rx_byte_in.valid && rx_check_in.crc_bad && rx_byte_in.last
    |=> word[BIT_CRC] && state_q == ST_DONE)
    else $error("crc error not in status word");
  AST_ONE_WORD_PER_FRAME: assert property (push && !pop |=> count == $past(count) + 1'b1)
    else $error("queue level did not follow the stored frame");

endmodule : rx_frame_header_status
`default_nettype wire

// ---- sim/rx_mac_model.sv ----
// receive mac model: sends whole frames as a byte stream with sticky check results
`default_nettype none
module rx_mac_model (
  input wire logic clk_in, // bench clock
  output var rx_status_pkg::rx_byte_s rx_byte_out, // byte stream into the block
  output var rx_status_pkg::rx_check_s rx_check_out // check results into the block
);
  timeunit 1ns;
  timeprecision 1ps;
  import rx_status_pkg::*;

  // stream is silent at time zero
  initial begin
    rx_byte_out = '0;
    rx_check_out = '0;
  end

  // one frame: dst0 picks the destination class, len bytes, type at bytes 12 and 13
  task automatic send(input logic [7:0] dst0, input int len, input logic [15:0] ltype, input rx_check_s chk);
    logic [7:0] d;
    for (int i = 0; i < len; i++) begin
      @(posedge clk_in);
      if (i == 0) d = dst0; // group bit rides in bit 0
      else if (i < 6) d = (dst0 == 8'hFF) ? 8'hFF : 8'h00; // rest of destination
      else if (i == 12) d = ltype[15:8]; // type high byte
      else if (i == 13) d = ltype[7:0]; // type low byte
      else d = 8'(i); // filler payload
      rx_byte_out <= '{valid: 1'b1, first: (i == 0), last: (i == len - 1), data: d};
      rx_check_out <= chk;
    end
    // between frames the lines show the inverse, so stale values cannot pass for real ones
    @(posedge clk_in);
    rx_byte_out <= '{valid: 1'b0, first: ~rx_byte_out.first, last: ~rx_byte_out.last, data: ~rx_byte_out.data};
    rx_check_out <= ~chk;
    // idle gap before any next frame or register read
    repeat (3) @(posedge clk_in);
  endtask : send
endmodule : rx_mac_model
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the receive frame status block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rx_status_pkg::*;

  logic clk_in = 1'b0; // 20 MHz clock
  logic srst_in = 1'b1; // reset held at start
  reg_req_s req = '0; // host request
  rx_byte_s rx_byte; // byte stream from the model
  rx_check_s rx_check; // check results from the model
  logic [15:0] rd_data; // read data
  logic pend; // status waiting
  logic dropped; // discard pulse
  int fail_count = 0; // mismatches
  int tests_run = 0; // comparisons
  int drops = 0; // discard pulses seen
  logic [15:0] r; // scratch read value
  // check results and the status bit each one must raise
  logic [6:0] ck [6] = '{7'h40, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01};
  logic [15:0] ex [6] = '{16'h0010, 16'h0001, 16'h2000, 16'h1000, 16'h0800, 16'h0400};
  // queue fill: destinations and the words expected back in order
  logic [7:0] dq [4] = '{8'hFF, 8'h01, 8'h02, 8'hFF};
  logic [15:0] eq [4] = '{16'h80C8, 16'h8048, 16'h8028, 16'h80C8};

  // clock, 50 ns period
  always #25 clk_in = ~clk_in;

  rx_mac_model i_mac (.clk_in(clk_in), .rx_byte_out(rx_byte), .rx_check_out(rx_check));

  // small queue so that a full queue is cheap to reach
  rx_frame_header_status #(.SLOT_BITS(2)) i_dut (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .rx_byte_in(rx_byte),
    .rx_check_in(rx_check),
    .reg_req_in(req),
    .rd_data_out(rd_data),
    .frame_pending_out(pend),
    .frame_dropped_out(dropped)
  );

  // count discard pulses, each lasts one cycle
  always @(posedge clk_in) begin
    if (dropped === 1'b1) drops++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_end(input string name);
    $display("test %s finished, %0d mismatches so far", name, fail_count);
  endtask : test_end

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // single-cycle write strobe
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    req <= '0;
  endtask : reg_write

  // single-cycle read strobe, data taken in the following cycle
  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_in);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_in);
    req <= '0;
    #1 d = rd_data;
  endtask : reg_read

  // hang guard: a run that outlives this bound is a failure
  initial begin
    repeat (100000) @(posedge clk_in);
    fail_count++;
    $display("unexpected at %0t: run did not complete", $time);
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    reg_read(STATUS_OFFSET, r);
    chk(r, 16'h0000);
    chk({15'h0000, pend}, 16'h0000);
    test_end("empty");
    // pass-bad off: good frame kept, bad ones discarded
    i_mac.send(8'h02, 64, 16'h0800, '0);
    chk({15'h0000, pend}, 16'h0001);
    reg_read(COUNT_OFFSET, r);
    chk(r, 16'h0001);
    reg_read(STATUS_OFFSET, r);
    chk(r, 16'h8028);
    reg_read(STATUS_OFFSET, r);
    chk(r, 16'h0000);
    i_mac.send(8'hFF, 64, 16'h05DC, 7'h10);
    i_mac.send(8'h02, 20, 16'h0800, '0);
    i_mac.send(8'h02, 2001, 16'h0800, '0);
    reg_read(COUNT_OFFSET, r);
    chk(r, 16'h0000);
    chk(16'(drops), 16'h0003);
    test_end("drop");
    // control readback, refused writes and an unmapped place
    reg_write(CTRL_OFFSET, 16'h0001);
    reg_write(STATUS_OFFSET, 16'hFFFF);
    reg_write(8'h00, 16'hFFFF);
    reg_read(CTRL_OFFSET, r);
    chk(r, 16'h0001);
    reg_read(8'h00, r);
    chk(r, 16'h0000);
    reg_read(STATUS_OFFSET, r);
    chk(r, 16'h0000);
    test_end("registers");
    // each checker result but collision raises its own bit, reserved bits stay zero
    for (int i = 0; i < 6; i++) begin
      i_mac.send(8'h02, 64, 16'h0600, ck[i]);
      reg_read(STATUS_OFFSET, r);
      chk(r, 16'h8028 | ex[i]);
    end
    test_end("checks");
    // destination classes and the type boundary at 1500
    i_mac.send(8'hFF, 64, 16'h05DC, '0);
    reg_read(STATUS_OFFSET, r);
    chk(r, 16'h80C0);
    i_mac.send(8'h01, 64, 16'h05DD, '0);
    reg_read(STATUS_OFFSET, r);
    chk(r, 16'h8048);
    // runts: type bit is meaningless there, so it is masked
    i_mac.send(8'h02, 20, 16'h0800, '0);
    reg_read(STATUS_OFFSET, r);
    chk(r & ~16'h0008, 16'h8022);
    i_mac.send(8'h02, 64, 16'h0800, 7'h20);
    reg_read(STATUS_OFFSET, r);
    chk(r & ~16'h0008, 16'h8022);
    // a frame of one byte goes straight to the commit cycle
    i_mac.send(8'h02, 1, 16'h0800, '0);
    reg_read(STATUS_OFFSET, r);
    chk(r, 16'h8022);
    // length boundary at 2000
    i_mac.send(8'h02, 2000, 16'h0800, '0);
    reg_read(STATUS_OFFSET, r);
    chk(r, 16'h8028);
    i_mac.send(8'h02, 2001, 16'h0800, '0);
    reg_read(STATUS_OFFSET, r);
    chk(r, 16'h802C);
    test_end("fields");
    // fill the four-slot queue, the fifth frame is discarded
    drops = 0;
    for (int i = 0; i < 5; i++) i_mac.send(dq[i % 4], 64, 16'h0600, '0);
    reg_read(COUNT_OFFSET, r);
    chk(r, 16'h0004);
    chk(16'(drops), 16'h0001);
    for (int i = 0; i < 4; i++) begin
      reg_read(STATUS_OFFSET, r);
      chk(r, eq[i]);
    end
    reg_read(STATUS_OFFSET, r);
    chk(r, 16'h0000);
    @(posedge clk_in);
    #1 chk({15'h0000, pend}, 16'h0000);
    test_end("queue");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
